//--- core/fbsf_consts.svh
// Offsets, bit positions and reset values of the flash bank status block.
// Assumes inclusion by bare name from any file that needs them.
`ifndef FBSF_CONSTS_SVH
`define FBSF_CONSTS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define FBSF_OFS_STATUS      8'h4C
`define FBSF_OFS_CONTROL     8'h50

// ==========================================================
// Status register fields
`define FBSF_BIT_BUSY        0
`define FBSF_BIT_SEQ         1
`define FBSF_BIT_NONERASED   2
`define FBSF_BIT_ALIGN       3
`define FBSF_BIT_PROTECT     4
`define FBSF_BIT_DONE        5
`define FBSF_BIT_BLANKFAIL   6
`define FBSF_BIT_INTERRUPTED 15
`define FBSF_STICKY_LO       1
`define FBSF_STICKY_HI       5
`define FBSF_RST_STATUS      32'h0000_0000

// ==========================================================
// Control register fields
`define FBSF_BIT_START       6
`define FBSF_BIT_FAULT_IE    10
`define FBSF_BIT_DONE_IE     12
`define FBSF_BIT_BLANKCHK    16
`define FBSF_RST_CONTROL     32'h0000_0000

// ==========================================================
// Bus constants
`define FBSF_BE_FULL         4'hF
`define FBSF_RD_UNMAPPED     32'h0000_0000

`endif

//--- core/fbsf_flag.sv
// One sticky flag: hardware sets it, a write of one clears it.
// Assumes set and clear come from logic on mclk.
`timescale 1ns/1ns
`default_nettype none

module fbsf_flag
	import fbsf_pkg::*;
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// Set and clear requests
	input  wire logic set_evt,
	input  wire logic clr_req,
	// Flag level
	output logic      flag_q
);

	// Set wins over a clear in the same cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			flag_q <= 1'b0;
		end else if (set_evt) begin
			flag_q <= 1'b1;
		end else if (clr_req) begin
			flag_q <= 1'b0;
		end
	end

endmodule

`default_nettype wire

//--- core/fbsf_pkg.sv
// Types shared by the flash bank status block.
// Assumes the constants header is compiled alongside.
package fbsf_pkg;

	// ==========================================================
	// Bus slave phase
	typedef enum logic [0:0] {
		bus_idle = 1'b0,
		bus_ack  = 1'b1
	} fbsf_bus_st_t;

	// Register word
	typedef logic [31:0] fbsf_word_t;

endpackage

//--- core/fbsf_status.sv
// Status flags and busy indication of one flash bank, with its control bits.
// Assumes an erase/program engine on mclk reporting one-cycle event pulses,
// and an Avalon-MM master on mclk for the register bus.
//
// Functional notes
// - An operation in progress when system reset or low supply strikes sets bit 15.
// - Bit 15 survives system reset and is cleared only by power-on reset or by a write of one.
// - After a blank check bit 6 reads 0 for an all-0xFF page and 1 otherwise.
// - A successfully finished erase or program sets the done flag at bit 5.
// - Sticky bits 1 to 6 and 15 clear on a write of one, a zero leaves them.
// - An erase or program on a protected page sets bit 4.
// - Misaligned program data on the data side bus sets bit 3.
// - Programming a location that is not 0xFFFF sets bit 2.
// - A program issued out of command order sets bit 1.
// - Bit 0 is high during an operation and drops at its end or on any error.
// - The start bit clears in the same cycle that busy drops.
// - The done interrupt request follows the done flag when its enable is set.
// - The fault interrupt request follows the error flags at bits 1 to 4 when its enable is set.
`timescale 1ns/1ns
`default_nettype none
`include "fbsf_consts.svh"

module fbsf_status
	import fbsf_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// Clock and resets
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic              por_rst,
	// Avalon-MM slave
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	// Engine commands
	output logic                   op_start,
	output logic                   blank_check_command,
	// Engine events, one-cycle pulses
	input  wire logic              eng_done,
	input  wire logic              eng_prot_err,
	input  wire logic              eng_align_err,
	input  wire logic              eng_nonerased_err,
	input  wire logic              eng_seq_err,
	input  wire logic              bc_done,
	input  wire logic              bc_nonblank,
	// Supply monitor pin, asynchronous
	input  wire logic              supply_low,
	// Interrupt requests
	output logic                   done_irq,
	output logic                   fault_irq
);

	// ==========================================================
	// Parameter check
	generate
		if (ADDR_W < 7 || ADDR_W > 8) begin : g_bad_addr
			$error("fbsf_status: ADDR_W must be 7 or 8");
		end
	endgenerate

	// ==========================================================
	// Declarations
	fbsf_bus_st_t bus_st_r;
	fbsf_word_t   rd_word;
	fbsf_word_t   readdata_r;
	logic [7:0]   addr8;
	logic         bus_req;
	logic         acc;
	logic         wr_ok;
	logic         wr_stat;
	logic         wr_ctl;
	logic         sup_meta_r;
	logic         sup_sync_r;
	logic         op_active_r;
	logic         start_r;
	logic         blank_r;
	logic         done_ie_r;
	logic         fault_ie_r;
	logic         bc_fail_r;
	logic         int_err_r;
	logic         any_err;
	logic         end_evt;
	logic         begin_evt;
	logic [`FBSF_STICKY_HI:`FBSF_STICKY_LO] flag_set;
	logic [`FBSF_STICKY_HI:`FBSF_STICKY_LO] flag_q;

	// ==========================================================
	// Bus decode
	always_comb begin
		addr8 = 8'h00;
		addr8[ADDR_W-1:0] = avs_address;
	end

	// Request and accept terms
	assign bus_req = avs_read | avs_write;
	assign acc     = (bus_st_r == bus_ack);
	assign wr_ok   = acc & avs_write & (avs_byteenable == `FBSF_BE_FULL);
	assign wr_stat = wr_ok & (addr8 == `FBSF_OFS_STATUS);
	assign wr_ctl  = wr_ok & (addr8 == `FBSF_OFS_CONTROL);

	// One wait cycle, then the answer
	assign avs_waitrequest = bus_req & (bus_st_r == bus_idle);

	// Bus phase
	always_ff @(posedge mclk) begin
		if (rst) begin
			bus_st_r <= bus_idle;
		end else begin
			case (bus_st_r)
				bus_idle: begin
					if (bus_req) begin
						bus_st_r <= bus_ack;
					end
				end
				bus_ack: begin
					bus_st_r <= bus_idle;
				end
				default: begin
					bus_st_r <= bus_idle;
				end
			endcase
		end
	end

	// Read mux, reserved bits zero
	always_comb begin
		rd_word = `FBSF_RD_UNMAPPED;
		if (addr8 == `FBSF_OFS_STATUS) begin
			rd_word[`FBSF_BIT_BUSY]        = op_active_r;
			rd_word[`FBSF_STICKY_HI:`FBSF_STICKY_LO] = flag_q;
			rd_word[`FBSF_BIT_BLANKFAIL]   = bc_fail_r;
			rd_word[`FBSF_BIT_INTERRUPTED] = int_err_r;
		end else if (addr8 == `FBSF_OFS_CONTROL) begin
			rd_word[`FBSF_BIT_START]    = start_r;
			rd_word[`FBSF_BIT_FAULT_IE] = fault_ie_r;
			rd_word[`FBSF_BIT_DONE_IE]  = done_ie_r;
			rd_word[`FBSF_BIT_BLANKCHK] = blank_r;
		end
	end

	// Read data captured as the answer starts
	always_ff @(posedge mclk) begin
		if (rst) begin
			readdata_r <= `FBSF_RST_STATUS;
		end else if (bus_st_r == bus_idle && avs_read) begin
			readdata_r <= rd_word;
		end
	end

	assign avs_readdata = readdata_r;

	// ==========================================================
	// Supply monitor synchroniser
	always_ff @(posedge mclk) begin
		if (rst) begin
			sup_meta_r <= 1'b0;
			sup_sync_r <= 1'b0;
		end else begin
			sup_meta_r <= supply_low;
			sup_sync_r <= sup_meta_r;
		end
	end

	// ==========================================================
	// Operation tracking
	assign any_err   = eng_prot_err | eng_align_err | eng_nonerased_err | eng_seq_err;
	assign end_evt   = op_active_r & (eng_done | any_err | bc_done | sup_sync_r);
	assign begin_evt = wr_ctl & ~op_active_r &
		(avs_writedata[`FBSF_BIT_START] | avs_writedata[`FBSF_BIT_BLANKCHK]);

	// Busy level
	always_ff @(posedge mclk) begin
		if (rst) begin
			op_active_r <= 1'b0;
		end else if (end_evt) begin
			op_active_r <= 1'b0;
		end else if (begin_evt) begin
			op_active_r <= 1'b1;
		end
	end

	// Start and blank check commands drop with busy
	always_ff @(posedge mclk) begin
		if (rst) begin
			start_r <= 1'b0;
			blank_r <= 1'b0;
		end else if (end_evt) begin
			start_r <= 1'b0;
			blank_r <= 1'b0;
		end else if (begin_evt) begin
			start_r <= avs_writedata[`FBSF_BIT_START];
			blank_r <= avs_writedata[`FBSF_BIT_BLANKCHK];
		end
	end

	assign op_start            = start_r;
	assign blank_check_command = blank_r;

	// Interrupt enables
	always_ff @(posedge mclk) begin
		if (rst) begin
			done_ie_r  <= 1'b0;
			fault_ie_r <= 1'b0;
		end else if (wr_ctl) begin
			done_ie_r  <= avs_writedata[`FBSF_BIT_DONE_IE];
			fault_ie_r <= avs_writedata[`FBSF_BIT_FAULT_IE];
		end
	end

	// ==========================================================
	// Sticky flags, bits 1 to 5
	always_comb begin
		flag_set = '0;
		flag_set[`FBSF_BIT_SEQ]       = eng_seq_err;
		flag_set[`FBSF_BIT_NONERASED] = eng_nonerased_err;
		flag_set[`FBSF_BIT_ALIGN]     = eng_align_err;
		flag_set[`FBSF_BIT_PROTECT]   = eng_prot_err;
		flag_set[`FBSF_BIT_DONE]      = op_active_r & eng_done & ~any_err;
	end

	generate
		for (genvar i = `FBSF_STICKY_LO; i <= `FBSF_STICKY_HI; i++) begin : g_flag
			fbsf_flag u_flag (
				.mclk    (mclk),
				.rst     (rst),
				.set_evt (flag_set[i]),
				.clr_req (wr_stat & avs_writedata[i]),
				.flag_q  (flag_q[i])
			);
		end
	endgenerate

	// Blank check result, loaded at each check end
	always_ff @(posedge mclk) begin
		if (rst) begin
			bc_fail_r <= 1'b0;
		end else if (op_active_r && bc_done) begin
			bc_fail_r <= bc_nonblank;
		end else if (wr_stat && avs_writedata[`FBSF_BIT_BLANKFAIL]) begin
			bc_fail_r <= 1'b0;
		end
	end

	// Interrupted operation, kept over system reset
	always_ff @(posedge mclk) begin
		if (por_rst) begin
			int_err_r <= 1'b0;
		end else if (op_active_r && (rst || sup_sync_r)) begin
			int_err_r <= 1'b1;
		end else if (wr_stat && avs_writedata[`FBSF_BIT_INTERRUPTED]) begin
			int_err_r <= 1'b0;
		end
	end

	// ==========================================================
	// Interrupt requests
	assign done_irq  = done_ie_r & flag_q[`FBSF_BIT_DONE];
	assign fault_irq = fault_ie_r & (|flag_q[`FBSF_BIT_PROTECT:`FBSF_BIT_SEQ]);

	// ==========================================================
	// Assertions
	sequence bus_start_s;
		bus_req && avs_waitrequest;
	endsequence

	sequence bus_answer_s;
		!avs_waitrequest;
	endsequence

	bus_answer_a: assert property (@(posedge mclk) disable iff (rst)
		bus_start_s |=> bus_answer_s)
		else $error("bus answer not one cycle after request");

	sequence op_run_s;
		op_active_r && !rst && !por_rst;
	endsequence

	sequence op_err_s;
		op_run_s ##0 any_err;
	endsequence

	busy_error_a: assert property (@(posedge mclk) disable iff (rst)
		op_err_s |=> !op_active_r)
		else $error("busy held after an error");

	busy_start_a: assert property (@(posedge mclk) disable iff (rst)
		begin_evt |=> op_active_r)
		else $error("busy not raised by a start write");

	start_drop_a: assert property (@(posedge mclk) disable iff (rst)
		$fell(op_active_r) |-> !start_r && !blank_r)
		else $error("start bit outlived busy");

	done_set_a: assert property (@(posedge mclk) disable iff (rst)
		op_run_s ##0 (eng_done && !any_err) |=> flag_q[`FBSF_BIT_DONE])
		else $error("done flag not set after success");

	protect_set_a: assert property (@(posedge mclk) disable iff (rst)
		eng_prot_err |=> flag_q[`FBSF_BIT_PROTECT])
		else $error("protection flag not set");

	align_set_a: assert property (@(posedge mclk) disable iff (rst)
		eng_align_err |=> flag_q[`FBSF_BIT_ALIGN])
		else $error("alignment flag not set");

	nonerased_set_a: assert property (@(posedge mclk) disable iff (rst)
		eng_nonerased_err |=> flag_q[`FBSF_BIT_NONERASED])
		else $error("non-erased write flag not set");

	seq_set_a: assert property (@(posedge mclk) disable iff (rst)
		eng_seq_err |=> flag_q[`FBSF_BIT_SEQ])
		else $error("sequence fault flag not set");

	zero_keep_a: assert property (@(posedge mclk) disable iff (rst)
		wr_stat && !avs_writedata[`FBSF_BIT_PROTECT] && flag_q[`FBSF_BIT_PROTECT]
		|=> flag_q[`FBSF_BIT_PROTECT])
		else $error("flag lost on a zero write");

	one_clear_a: assert property (@(posedge mclk) disable iff (rst)
		wr_stat && avs_writedata[`FBSF_BIT_ALIGN] && !eng_align_err
		|=> !flag_q[`FBSF_BIT_ALIGN])
		else $error("flag kept after a one write");

	blank_result_a: assert property (@(posedge mclk) disable iff (rst)
		op_active_r && bc_done |=> bc_fail_r == $past(bc_nonblank))
		else $error("blank check result wrong");

	reset_catch_a: assert property (@(posedge mclk) disable iff (por_rst)
		rst && op_active_r |=> int_err_r)
		else $error("interrupted flag not set by reset");

	reset_keep_a: assert property (@(posedge mclk) disable iff (por_rst)
		rst && int_err_r && !wr_stat |=> int_err_r [*2])
		else $error("interrupted flag lost over system reset");

	por_clear_a: assert property (@(posedge mclk)
		por_rst |=> !int_err_r)
		else $error("interrupted flag survived power-on reset");

	done_irq_a: assert property (@(posedge mclk) disable iff (rst)
		flag_q[`FBSF_BIT_DONE] && !done_ie_r |-> !done_irq)
		else $error("done request without enable");

	done_req_a: assert property (@(posedge mclk) disable iff (rst)
		op_run_s ##0 (eng_done && !any_err && done_ie_r && !wr_ctl) |=> done_irq)
		else $error("done request missing after success");

	fault_irq_a: assert property (@(posedge mclk) disable iff (rst)
		eng_seq_err && fault_ie_r && !wr_ctl |=> fault_irq)
		else $error("fault request missing");

endmodule

`default_nettype wire

//--- sim/fbsf_status_test.sv
// Self-checking bench for the flash bank status flags block.
// Assumes the package and the constants header are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`include "fbsf_consts.svh"

module fbsf_status_test import fbsf_pkg::*;;
	// ==========================================================
	// Signals
	logic        mclk = 1'b0;
	logic        rst, por_rst, avs_read, avs_write, avs_waitrequest;
	logic [7:0]  avs_address;
	logic [3:0]  avs_byteenable;
	fbsf_word_t  avs_writedata, avs_readdata, rd;
	logic [5:0]  evt;
	logic        bc_nonblank, supply_low, op_start, blank_check_command;
	logic        done_irq, fault_irq;
	int          bad_count, checks_done, en, nb;

	// Clock at 50 MHz
	always #10 mclk = ~mclk;

	// Device under test
	fbsf_status #(.ADDR_W(8)) fbsf_status_inst (
		.mclk(mclk), .rst(rst), .por_rst(por_rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.op_start(op_start), .blank_check_command(blank_check_command),
		.eng_done(evt[0]), .eng_seq_err(evt[1]), .eng_nonerased_err(evt[2]),
		.eng_align_err(evt[3]), .eng_prot_err(evt[4]), .bc_done(evt[5]),
		.bc_nonblank(bc_nonblank), .supply_low(supply_low),
		.done_irq(done_irq), .fault_irq(fault_irq)
	);

	// ==========================================================
	// Helpers
	function automatic fbsf_word_t bit_at(input int i);
		return 32'h0000_0001 << i;
	endfunction

	// Compare one value
	task automatic chk(input fbsf_word_t seen, input fbsf_word_t exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One Avalon access; holds until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input fbsf_word_t d,
			input logic [3:0] be, output fbsf_word_t q);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address    <= a;
		avs_write      <= wr;
		avs_read       <= ~wr;
		avs_writedata  <= d;
		avs_byteenable <= be;
		// Sample waitrequest at each rising edge; only the watchdog ends a hang
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0);
		chk(n, 2); // One wait state, answer at the second edge
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// Read the status word
	task automatic rd_stat();
		bus(1'b0, `FBSF_OFS_STATUS, 32'h0000_0000, 4'hF, rd);
	endtask

	// Write the status word with full byte enables
	task automatic wr_stat(input fbsf_word_t d);
		bus(1'b1, `FBSF_OFS_STATUS, d, 4'hF, rd);
	endtask

	// Launch an operation with extra control bits
	task automatic start(input fbsf_word_t extra);
		bus(1'b1, `FBSF_OFS_CONTROL, 32'h0000_0040 | extra, 4'hF, rd);
		@(negedge mclk);
		chk({31'h0, op_start}, 32'h0000_0001);
	endtask

	// One-cycle engine event
	task automatic fire(input int i);
		@(posedge mclk);
		evt[i] <= 1'b1;
		@(posedge mclk);
		evt <= 6'h00;
	endtask

	// Pulse the system reset for two edges
	task automatic sys_reset();
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
	endtask

	// Verdict and end of run
	task automatic test_done();
		$display("checks=%0d mismatches=%0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Watchdog, far beyond the few hundred cycles of the run
	initial begin
		#200000;
		bad_count++;
		test_done();
	end

	// ==========================================================
	// Main sequence
	initial begin
		rst = 1'b1; por_rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0;
		avs_address = 8'h00; avs_writedata = 32'h0; avs_byteenable = 4'hF;
		evt = 6'h00; bc_nonblank = 1'b0; supply_low = 1'b0;
		bad_count = 0; checks_done = 0;
		void'($urandom(32'hce6caee3));
		repeat (16) @(posedge mclk);
		rst <= 1'b0; por_rst <= 1'b0;

		// Reset values and unmapped place
		rd_stat(); chk(rd, `FBSF_RST_STATUS);
		bus(1'b0, `FBSF_OFS_CONTROL, 32'h0, 4'hF, rd); chk(rd, `FBSF_RST_CONTROL);
		bus(1'b0, 8'h10, 32'h0, 4'hF, rd); chk(rd, `FBSF_RD_UNMAPPED);
		$display("test reset done");

		// Busy then successful end
		start(32'h0000_1000);
		rd_stat(); chk(rd, 32'h0000_0001);
		fire(0);
		rd_stat(); chk(rd, 32'h0000_0020);
		chk({31'h0, op_start}, 32'h0);
		chk({31'h0, done_irq}, 32'h1);
		wr_stat(32'h0000_0000); rd_stat(); chk(rd, 32'h0000_0020);
		bus(1'b1, `FBSF_OFS_STATUS, 32'h20, 4'h3, rd); rd_stat(); chk(rd, 32'h20);
		wr_stat(32'h0000_0020); rd_stat(); chk(rd, 32'h0000_0000);
		chk({31'h0, done_irq}, 32'h0);
		start(32'h0000_0000);
		fire(0);
		rd_stat();
		chk(rd, 32'h0000_0020);
		chk({31'h0, done_irq}, 32'h0);
		wr_stat(32'h0000_0020);
		$display("test done_flag done");

		// Each fault ends the operation and sets its own flag
		for (int i = 1; i <= 4; i++) begin
			en = (i == 1) ? 1 : ((i == 2) ? 0 : $urandom % 2);
			start(en ? 32'h0000_0400 : 32'h0000_0000);
			fire(i);
			rd_stat(); chk(rd, bit_at(i));
			chk({31'h0, op_start}, 32'h0);
			chk({31'h0, fault_irq}, en);
			wr_stat(($urandom & 32'h0000_807E) & ~bit_at(i));
			rd_stat(); chk(rd, bit_at(i));
			chk({31'h0, fault_irq}, en);
			wr_stat(bit_at(i)); rd_stat(); chk(rd, 32'h0);
			chk({31'h0, fault_irq}, 32'h0);
		end
		$display("test faults done");

		// Blank check with both outcomes
		for (int k = 0; k < 3; k++) begin
			nb = (k < 2) ? (k == 0) : ($urandom % 2);
			start(32'h0001_0000);
			chk({31'h0, blank_check_command}, 32'h1);
			@(posedge mclk);
			bc_nonblank <= nb[0];
			fire(5);
			rd_stat(); chk(rd, nb ? 32'h40 : 32'h0);
			wr_stat(32'h0000_0040); rd_stat(); chk(rd, 32'h0);
		end
		$display("test blank_check done");

		// System reset during an operation
		start(32'h0000_0000);
		sys_reset();
		rd_stat(); chk(rd, 32'h0000_8000);
		chk({31'h0, op_start}, 32'h0);
		sys_reset();
		rd_stat(); chk(rd, 32'h0000_8000);
		@(posedge mclk); por_rst <= 1'b1; rst <= 1'b1;
		@(posedge mclk); por_rst <= 1'b0; rst <= 1'b0;
		rd_stat(); chk(rd, 32'h0000_0000);
		$display("test reset_capture done");

		// Low supply during an operation
		start(32'h0000_0000);
		@(posedge mclk); supply_low <= 1'b1;
		repeat (6) @(posedge mclk);
		supply_low <= 1'b0;
		repeat (4) @(posedge mclk);
		rd_stat(); chk(rd, 32'h0000_8000);
		wr_stat(32'h0000_8000); rd_stat(); chk(rd, 32'h0);
		$display("test supply_low done");
		test_done();
	end
endmodule
`default_nettype wire
